//--- verilog/ref_consts.svh
`ifndef REF_CONSTS_SVH
`define REF_CONSTS_SVH

// ****************************************************************
// training register address and field layout
// ****************************************************************
`define TRAIN_REG_ADDR 3'h6
`define TRAIN_EN_BIT 7
`define RANGE_SEL_BIT 6
`define LEVEL_MSB 5
`define FIRST_RESERVED_CODE 6'h33
`define LAST_VALID_CODE 6'h32

// ****************************************************************
// reference levels, hundredths of a percent of output supply
// ****************************************************************
`define RANGE1_BASE 14'h1770
`define RANGE2_BASE 14'h1194
`define LEVEL_STEP 14'h0041

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 40
`define STEP_TIME_NS 150
`define MON_BASE_NS 10
`define MON_PER_PF_NS 15
`define SETTLE_CYC (`STEP_TIME_NS / `CLK_PERIOD_NS)

// ****************************************************************
// controller register map and fields
// ****************************************************************
`define CTRL_OFS 4'h0
`define MON_OFS 4'h4
`define SWEEP_OFS 4'h8
`define STAT_OFS 4'hc
`define CTRL_RST 9'h100
`define AUTO_TRAIN_BIT 8
`define MON_EN_BIT 0
`define ST_BUSY 0
`define ST_REFUSED 2
`define ST_FOUND 3

`endif

//--- verilog/ref_pkg.sv
package ref_pkg;

    // device end: holding the level or settling to a new one
    typedef enum logic [0:0] {
        DEV_HOLD = 1'h0,
        DEV_SETTLE = 1'h1
    } dev_state_t;

    // controller end sequencing
    typedef enum logic [1:0] {
        CTL_IDLE = 2'h0,
        CTL_WAIT = 2'h1,
        CTL_CENTER = 2'h2
    } ctl_state_t;

endpackage

//--- verilog/ref_link_if.sv
`timescale 1ns/100ps

// ****************************************************************
// mode register set link, controller to device
// ****************************************************************
interface ref_link_if;
    logic set_valid;
    logic [2:0] set_reg;
    logic [7:0] set_op;

    modport device (
        input set_valid,
        input set_reg,
        input set_op
    );

    modport controller (
        output set_valid,
        output set_reg,
        output set_op
    );
endinterface

//--- verilog/ref_level_dev.sv
// Operation
// - reference made inside, set only by command
// - range bit 0 from 60%, 1 from 45%
// - level code adds 0.65% steps from base
// - controller never sends reserved codes 0x33-0x3f
// - range and level apply regardless of training bit
// - controller sets training bit when changing setting; here single writes only with auto-train or bit 7 set
// - training bit kept on through calibration rewrites
// - one-step change settles within 150 ns
// - any larger change also settles within 150 ns
// - monitor on adds 10 ns plus 15 ns/pF
// - n code steps move level n steps
// - controller sweeps the reference to calibrate
`timescale 1ns/100ps
`include "ref_consts.svh"

module ref_level_dev (
    input wire logic clk_i,
    input wire logic rst_b_i,
    ref_link_if.device link,
    output logic ref_range_o,
    output logic [5:0] ref_code_o,
    output logic train_en_o,
    output logic [13:0] ref_level_o,
    output logic [13:0] ref_target_o,
    output logic ref_settled_o,
    output logic reserved_code_o,
    output logic [5:0] ref_steps_o,
    output logic ref_step_up_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic range_q;
    logic [5:0] code_q;
    logic train_q;
    logic reserved_q;
    logic [13:0] target_q;
    logic [13:0] level_q;
    logic [2:0] cnt_q;
    logic [5:0] steps_q;
    logic step_up_q;
    ref_pkg::dev_state_t state_q;
    ref_pkg::dev_state_t state_d;

    // ****************************************************************
    // command decode
    // ****************************************************************

    // only a command to the training register is taken
    wire logic hit;
    assign hit = link.set_valid
        && (link.set_reg == `TRAIN_REG_ADDR);

    // fields of the incoming operand
    wire logic new_range;
    wire logic [5:0] new_code;
    wire logic new_train;
    assign new_range = link.set_op[`RANGE_SEL_BIT];
    assign new_code = link.set_op[`LEVEL_MSB:0];
    assign new_train = link.set_op[`TRAIN_EN_BIT];

    // reserved codes leave the analog target alone
    wire logic new_reserved;
    assign new_reserved = (new_code >= `FIRST_RESERVED_CODE);

    // ****************************************************************
    // level arithmetic
    // ****************************************************************

    // base of the chosen range
    wire logic [13:0] new_base;
    assign new_base = new_range ? `RANGE2_BASE
        : `RANGE1_BASE;

    // linear ladder above the base
    wire logic [13:0] new_offset;
    assign new_offset = {8'h00, new_code} * `LEVEL_STEP;

    wire logic [13:0] new_target;
    assign new_target = new_base + new_offset;

    // size and direction of the move, in code steps
    wire logic new_up;
    wire logic [5:0] new_steps;
    assign new_up = (new_code > code_q);
    assign new_steps = new_up ? (new_code - code_q)
        : (code_q - new_code);

    // ****************************************************************
    // settled field capture
    // ****************************************************************

    // range, code and training bit held until next command
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            range_q <= 1'h0;
            code_q <= 6'h00;
            train_q <= 1'h0;
            reserved_q <= 1'h0;
        end
        else if (hit)
        begin
            range_q <= new_range;
            code_q <= new_code;
            train_q <= new_train;
            reserved_q <= new_reserved;
        end
    end

    // ****************************************************************
    // target level
    // ****************************************************************

    // target follows every valid code, training bit ignored
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            target_q <= `RANGE1_BASE;
        end
        else if (hit && !new_reserved)
        begin
            target_q <= new_target;
        end
    end

    // ****************************************************************
    // step report
    // ****************************************************************

    // step count and direction of the latest move
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            steps_q <= 6'h00;
            step_up_q <= 1'h0;
        end
        else if (hit && !new_reserved)
        begin
            steps_q <= new_steps;
            step_up_q <= new_up;
        end
    end

    // ****************************************************************
    // settling sequence
    // ****************************************************************

    // counter expires after SETTLE_CYC cycles (3 clocks, 120 ns), whatever the jump
    wire logic settle_done;
    assign settle_done = (state_q == ref_pkg::DEV_SETTLE)
        && (cnt_q == 3'h0);

    // next state; a new command restarts the settle
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ref_pkg::DEV_HOLD:
            begin
                if (hit)
                begin
                    state_d = ref_pkg::DEV_SETTLE;
                end
            end
            ref_pkg::DEV_SETTLE:
            begin
                if (hit)
                begin
                    state_d = ref_pkg::DEV_SETTLE;
                end
                else if (settle_done)
                begin
                    state_d = ref_pkg::DEV_HOLD;
                end
            end
            default:
            begin
                state_d = ref_pkg::DEV_HOLD;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= ref_pkg::DEV_HOLD;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // settle countdown, same length for one step or full range
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= 3'h0;
        end
        else if (hit)
        begin
            cnt_q <= 3'(`SETTLE_CYC) - 3'h1;
        end
        else if (cnt_q != 3'h0)
        begin
            cnt_q <= cnt_q - 3'h1;
        end
    end

    // ****************************************************************
    // generated reference
    // ****************************************************************

    // internal level moves to the target when settling ends
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            level_q <= `RANGE1_BASE;
        end
        else if (settle_done && !hit)
        begin
            level_q <= target_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // all from flip-flops except the settled flag
    assign ref_range_o = range_q;
    assign ref_code_o = code_q;
    assign train_en_o = train_q;
    assign ref_level_o = level_q;
    assign ref_target_o = target_q;
    assign ref_settled_o = (state_q == ref_pkg::DEV_HOLD);
    assign reserved_code_o = reserved_q;
    assign ref_steps_o = steps_q;
    assign ref_step_up_o = step_up_q;

endmodule

//--- verilog/ref_level_ctl.sv
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "ref_consts.svh"

module ref_level_ctl (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic eye_pass_i,
    output logic sample_o,
    output logic busy_o,
    ref_link_if.controller link
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic ack_q;
    logic [31:0] rdata_q;
    logic [8:0] ctrl_q;
    logic mon_en_q;
    logic [7:0] pf_q;
    logic refused_q;
    logic found_q;
    logic [5:0] lo_q;
    logic [5:0] hi_q;
    logic [5:0] code_q;
    logic sw_range_q;
    logic sweeping_q;
    logic [12:0] elapsed_q;
    logic set_valid_q;
    logic [7:0] set_op_q;
    ref_pkg::ctl_state_t state_q;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire logic acc;
    wire logic wr;
    wire logic wr_ctrl;
    wire logic wr_mon;
    wire logic wr_sweep;
    wire logic clr_ref;
    assign acc = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign wr_ctrl = wr && (wb_adr_i == `CTRL_OFS);
    assign wr_mon = wr && (wb_adr_i == `MON_OFS);
    assign wr_sweep = wr && (wb_adr_i == `SWEEP_OFS);
    assign clr_ref = wr && (wb_adr_i == `STAT_OFS)
        && wb_dat_i[`ST_REFUSED];

    // ****************************************************************
    // command acceptance
    // ****************************************************************
    wire logic busy;
    wire logic bad_code;
    wire logic go_single;
    wire logic go_sweep;
    wire logic refuse;
    assign busy = (state_q != ref_pkg::CTL_IDLE);
    assign bad_code = (wb_dat_i[`LEVEL_MSB:0] >= `FIRST_RESERVED_CODE);
    assign go_single = wr_ctrl && !busy && !bad_code;
    assign go_sweep = wr_sweep && !busy;
    assign refuse = (wr_ctrl && (busy || bad_code)) || (wr_sweep && busy);

    // training bit forced on when auto-train is set
    wire logic auto_eff;
    wire logic [7:0] single_op;
    assign auto_eff = wb_sel_i[1] ? wb_dat_i[`AUTO_TRAIN_BIT]
        : ctrl_q[`AUTO_TRAIN_BIT];
    assign single_op = {wb_dat_i[`TRAIN_EN_BIT] || auto_eff,
        wb_dat_i[6:0]};

    // ****************************************************************
    // settle wait and sweep steering
    // ****************************************************************

    // wait from the edge the device takes the command
    wire logic [12:0] mon_ns;
    wire logic [12:0] wait_ns;
    wire logic done;
    assign mon_ns = mon_en_q ? (13'(`MON_BASE_NS)
        + {5'h00, pf_q} * 13'(`MON_PER_PF_NS)) : 13'h0000;
    assign wait_ns = 13'(`STEP_TIME_NS) + 13'(`CLK_PERIOD_NS) + mon_ns;
    assign done = (state_q == ref_pkg::CTL_WAIT)
        && (elapsed_q >= wait_ns);

    wire logic samp;
    wire logic sweep_adv;
    wire logic center_issue;
    wire logic [6:0] lo_hi_sum;
    wire logic [5:0] mid;
    assign samp = done && sweeping_q;
    assign sweep_adv = samp && (code_q != `LAST_VALID_CODE);
    assign center_issue = (state_q == ref_pkg::CTL_CENTER) && found_q;
    assign lo_hi_sum = {1'h0, lo_q} + {1'h0, hi_q};
    assign mid = lo_hi_sum[6:1];

    // operand for the next command; sweep keeps training on
    wire logic issue;
    wire logic [7:0] next_op;
    assign issue = go_single || go_sweep || sweep_adv || center_issue;
    assign next_op = go_single ? single_op
        : go_sweep ? {1'h1, wb_dat_i[`RANGE_SEL_BIT], 6'h00}
        : center_issue ? {1'h1, sw_range_q, mid}
        : {1'h1, sw_range_q, code_q + 6'h01};

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= ref_pkg::CTL_IDLE;
            sweeping_q <= 1'h0;
        end
        else
        begin
            case (state_q)
                ref_pkg::CTL_IDLE:
                begin
                    if (go_single || go_sweep)
                    begin
                        state_q <= ref_pkg::CTL_WAIT;
                    end
                    sweeping_q <= go_sweep;
                end
                ref_pkg::CTL_WAIT:
                begin
                    if (done && !sweep_adv)
                    begin
                        state_q <= sweeping_q ? ref_pkg::CTL_CENTER
                            : ref_pkg::CTL_IDLE;
                    end
                end
                ref_pkg::CTL_CENTER:
                begin
                    state_q <= found_q ? ref_pkg::CTL_WAIT
                        : ref_pkg::CTL_IDLE;
                    sweeping_q <= 1'h0;
                end
                default:
                begin
                    state_q <= ref_pkg::CTL_IDLE;
                end
            endcase
        end
    end

    // elapsed time and sweep position
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            elapsed_q <= 13'h0000;
            code_q <= 6'h00;
            sw_range_q <= 1'h0;
        end
        else
        begin
            if (issue)
                elapsed_q <= 13'h0000;
            else if ((state_q == ref_pkg::CTL_WAIT) && !done)
                elapsed_q <= elapsed_q + 13'(`CLK_PERIOD_NS);
            if (go_sweep)
                code_q <= 6'h00;
            else if (sweep_adv)
                code_q <= code_q + 6'h01;
            if (go_sweep)
                sw_range_q <= wb_dat_i[`RANGE_SEL_BIT];
        end
    end

    // passing window of the sweep
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            found_q <= 1'h0;
            lo_q <= 6'h00;
            hi_q <= 6'h00;
        end
        else if (go_sweep)
            found_q <= 1'h0;
        else if (samp && eye_pass_i)
        begin
            found_q <= 1'h1;
            hi_q <= code_q;
            if (!found_q)
                lo_q <= code_q;
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_q <= `CTRL_RST;
            mon_en_q <= 1'h0;
            pf_q <= 8'h00;
            refused_q <= 1'h0;
        end
        else
        begin
            if (go_single)
                ctrl_q <= {auto_eff, single_op};
            else if (center_issue)
                ctrl_q[7:0] <= {1'h1, sw_range_q, mid};
            if (wr_mon)
                mon_en_q <= wb_dat_i[`MON_EN_BIT];
            if (wr_mon && wb_sel_i[1])
                pf_q <= wb_dat_i[15:8];
            if (refuse)
                refused_q <= 1'h1;
            else if (clr_ref)
                refused_q <= 1'h0;
        end
    end

    // read selection; unmapped reads return zero
    wire logic [31:0] rd_mux;
    assign rd_mux = (wb_adr_i == `CTRL_OFS) ? {23'h0, ctrl_q}
        : (wb_adr_i == `MON_OFS) ? {16'h0, pf_q, 7'h0, mon_en_q}
        : (wb_adr_i == `SWEEP_OFS) ? {25'h0, sw_range_q, 6'h00}
        : (wb_adr_i == `STAT_OFS) ? {2'h0, code_q, 2'h0, hi_q, 2'h0,
            lo_q, 4'h0, found_q, refused_q, 1'h0, busy}
        : 32'h0;

    // one-cycle ack with registered data
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ack_q <= 1'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            ack_q <= acc;
            if (acc)
                rdata_q <= rd_mux;
        end
    end

    // command link register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            set_valid_q <= 1'h0;
            set_op_q <= 8'h00;
        end
        else
        begin
            set_valid_q <= issue;
            if (issue)
                set_op_q <= next_op;
        end
    end

    assign link.set_valid = set_valid_q;
    assign link.set_reg = `TRAIN_REG_ADDR;
    assign link.set_op = set_op_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign sample_o = samp;
    assign busy_o = busy;

endmodule

//--- tb/ref_link_properties.sv
`timescale 1ns/100ps
`include "ref_consts.svh"

// ****************************************************************
// link and device output checks
// ****************************************************************
module ref_link_properties (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic set_valid,
    input wire logic [2:0] set_reg,
    input wire logic [7:0] set_op,
    input wire logic ref_range_o,
    input wire logic [5:0] ref_code_o,
    input wire logic train_en_o,
    input wire logic [13:0] ref_level_o,
    input wire logic [13:0] ref_target_o,
    input wire logic ref_settled_o,
    input wire logic [5:0] ref_steps_o,
    input wire logic ref_step_up_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // command to the training register, and one with a legal code
    sequence s_cmd;
        set_valid && set_reg == `TRAIN_REG_ADDR;
    endsequence
    sequence s_good;
        s_cmd ##0 set_op[5:0] <= `LAST_VALID_CODE;
    endsequence

    property p_pulse;
        set_valid |=> !set_valid;
    endproperty
    property p_addr;
        set_valid |-> set_reg == `TRAIN_REG_ADDR;
    endproperty
    property p_legal;
        set_valid |-> set_op[5:0] <= `LAST_VALID_CODE;
    endproperty
    property p_capture;
        s_cmd |=> ref_code_o == $past(set_op[5:0])
            && ref_range_o == $past(set_op[6])
            && train_en_o == $past(set_op[7]);
    endproperty
    property p_hold;
        !set_valid |=> $stable(ref_code_o) && $stable(ref_range_o);
    endproperty
    property p_settle;
        s_cmd |=> !ref_settled_o ##[1:3] ref_settled_o;
    endproperty
    property p_target;
        s_good |=> ref_target_o == ($past(set_op[6]) ? `RANGE2_BASE
            : `RANGE1_BASE) + {8'h00, $past(set_op[5:0])} * `LEVEL_STEP;
    endproperty
    property p_level;
        $rose(ref_settled_o) |-> ref_level_o == ref_target_o;
    endproperty
    property p_steps;
        s_good |=> ref_step_up_o == ($past(set_op[5:0]) > $past(ref_code_o))
            && ref_steps_o == (ref_step_up_o ? ref_code_o - $past(ref_code_o)
            : $past(ref_code_o) - ref_code_o);
    endproperty

    a_pulse: assert property (p_pulse)
        else $error("command strobe longer than one cycle");
    a_addr: assert property (p_addr)
        else $error("command to wrong register");
    a_legal: assert property (p_legal)
        else $error("reserved level code sent");
    a_capture: assert property (p_capture)
        else $error("fields not captured");
    a_hold: assert property (p_hold)
        else $error("fields changed without command");
    a_settle: assert property (p_settle)
        else $error("settle window wrong");
    a_target: assert property (p_target)
        else $error("target level wrong");
    a_level: assert property (p_level)
        else $error("level not at target when settled");
    a_steps: assert property (p_steps)
        else $error("step count or direction wrong");
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
`include "ref_consts.svh"

module testbench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, eye_pass_i = 1'b0, sample_o, busy_o;
    logic ref_range_o, train_en_o, ref_settled_o, ref_step_up_o;
    logic reserved_code_o;
    logic [5:0] ref_code_o, ref_steps_o, prev = 6'h00;
    logic [13:0] ref_level_o, ref_target_o;
    int n_errors = 0, n_checks = 0, n_samples = 0, cnt, c0;
    logic [8:0] codes [6] = '{9'h100, 9'h101, 9'h132, 9'h140, 9'h172,
        9'h119};

    // ************************************************************
    // design, link and checker
    // ************************************************************
    ref_link_if u_ref_link_if ();
    ref_level_dev u_ref_level_dev (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .link(u_ref_link_if), .ref_range_o(ref_range_o),
        .ref_code_o(ref_code_o), .train_en_o(train_en_o),
        .ref_level_o(ref_level_o), .ref_target_o(ref_target_o),
        .ref_settled_o(ref_settled_o), .reserved_code_o(reserved_code_o),
        .ref_steps_o(ref_steps_o), .ref_step_up_o(ref_step_up_o));
    ref_level_ctl u_ref_level_ctl (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .eye_pass_i(eye_pass_i), .sample_o(sample_o), .busy_o(busy_o),
        .link(u_ref_link_if));
    ref_link_properties u_ref_link_properties (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .set_valid(u_ref_link_if.set_valid),
        .set_reg(u_ref_link_if.set_reg), .set_op(u_ref_link_if.set_op),
        .ref_range_o(ref_range_o), .ref_code_o(ref_code_o),
        .train_en_o(train_en_o), .ref_level_o(ref_level_o),
        .ref_target_o(ref_target_o), .ref_settled_o(ref_settled_o),
        .ref_steps_o(ref_steps_o), .ref_step_up_o(ref_step_up_o));

    always #20 clk_i = ~clk_i;

    // eye passes for codes 0x10..0x20, count sweep points
    always @(posedge clk_i)
    begin
        eye_pass_i <= ref_code_o >= 6'h10 && ref_code_o <= 6'h20;
        if (sample_o === 1'b1)
            n_samples++;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic wishbone cycle, held until ack is sampled
    task automatic wb_io(input logic we, input logic [3:0] adr,
        input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_idle(input int lim);
        cnt = 0;
        while (busy_o !== 1'b0 && cnt < lim)
        begin
            cnt++;
            @(posedge clk_i);
        end
        if (cnt >= lim)
            n_errors++;
    endtask

    // program range and level, then compare device outputs
    task automatic set_ref(input logic [8:0] v);
        logic [13:0] base;
        logic [5:0] c;
        wb_io(1'b1, `CTRL_OFS, {23'h0, v});
        wait_idle(100);
        base = v[6] ? `RANGE2_BASE : `RANGE1_BASE;
        c = v[5:0];
        check(ref_range_o, v[6]);
        check(ref_code_o, v[5:0]);
        check(train_en_o, v[8] | v[7]);
        check(ref_level_o, base + {8'h0, c} * `LEVEL_STEP);
        check(ref_step_up_o, c > prev);
        check(ref_steps_o, c > prev ? c - prev : prev - c);
        prev = v[5:0];
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        check(ref_level_o, `RANGE1_BASE);
        check(ref_settled_o, 1'b1);
        wb_io(1'b0, `CTRL_OFS, 32'h0);
        check(rd, `CTRL_RST);
        wb_io(1'b0, 4'h6, 32'h0);
        check(rd, 32'h0);
        foreach (codes[i])
            set_ref(codes[i]);
        set_ref(9'h02a);
        set_ref(9'h0ea);
        // reserved code and write while busy are both refused
        wb_io(1'b1, `CTRL_OFS, 32'h133);
        wait_idle(100);
        check(ref_code_o, prev);
        check(reserved_code_o, 1'b0);
        wb_io(1'b1, `CTRL_OFS, 32'h105);
        wb_io(1'b1, `CTRL_OFS, 32'h110);
        wait_idle(100);
        check(ref_code_o, 6'h05);
        prev = 6'h05;
        wb_io(1'b0, `STAT_OFS, 32'h0);
        check(rd[`ST_REFUSED], 1'b1);
        wb_io(1'b1, `STAT_OFS, 32'h4);
        wb_io(1'b0, `STAT_OFS, 32'h0);
        check(rd, 32'h0);
        // monitor with 4 pF stretches the wait by two cycles
        set_ref(9'h106);
        c0 = cnt;
        wb_io(1'b1, `MON_OFS, 32'h401);
        wb_io(1'b0, `MON_OFS, 32'h0);
        check(rd, 32'h401);
        set_ref(9'h107);
        check(cnt - c0, 2);
        wb_io(1'b1, `MON_OFS, 32'h0);
        // sweep range 2, passing window 0x10..0x20
        wb_io(1'b1, `SWEEP_OFS, 32'h40);
        wait_idle(5000);
        check(n_samples, 51);
        wb_io(1'b0, `STAT_OFS, 32'h0);
        check(rd[21:0], 22'h20_1008);
        check(ref_code_o, 6'h18);
        check(train_en_o, 1'b1);
        check(ref_level_o, `RANGE2_BASE + 14'h18 * `LEVEL_STEP);
        final_report;
    end

    // watchdog over the whole run
    initial
    begin
        #(40 * 20000);
        n_errors++;
        final_report;
    end
endmodule
